//--- rtl/dps_mode_switch.sv
`timescale 1ns/100ps
module dps_mode_switch
	import dps_pkg::*;
(
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic tck, // probe test clock / serial clock
	input wire logic tms_in, // mode-select / serial data pin level
	input wire logic ext_rst_n, // external reset pin, low active
	input wire logic cfg_wr, // pin config write strobe
	input wire logic [1:0] cfg_sel, // which config field is written
	input wire logic [4:0] cfg_data, // config write data
	input wire logic lock_wr, // lock key write strobe
	input wire logic [31:0] lock_key, // lock key value
	input wire logic commit_wr, // commit control write strobe
	input wire logic [4:0] commit_data, // commit control data
	input wire logic dbg_restore, // restore debug pin functions
	input wire logic flash_erase_done, // flash mass erase finished
	input wire logic nv_restore_done, // nonvolatile defaults restored
	output dps_pin_cfg_t pin_cfg, // pin function configuration
	output logic pin_unlocked, // lock open
	output logic [4:0] pin_commit, // commit control bits
	output logic flash_erase_req, // mass erase request
	output logic nv_restore_req, // nonvolatile restore request
	output dps_mode_t port_mode, // current debug port mode (tck domain)
	output logic line_reset, // fifty-ones line reset seen (tck domain)
	output dps_tap_t tap_state, // TAP controller state (tck domain)
	output logic [3:0] ir_value // current instruction (tck domain)
);
	// ********************************************
	// Crossings
	// ********************************************
	logic rst_tck;
	logic ext_rst_tck_n;
	logic ext_rst_clk_n;
	logic [4:0] dbg_en_tck;
	logic erase_tgl_r;
	logic erase_lvl;
	dps_pin_cfg_t cfg_r;

	dps_sync #(.W(1), .RST_VAL(1'h1)) u_rst_tck (
		.clk(tck),
		.rst(1'b0),
		.d(rst),
		.q(rst_tck)
	);
	dps_sync #(.W(1), .RST_VAL(1'h1)) u_xrst_tck (
		.clk(tck),
		.rst(rst_tck),
		.d(ext_rst_n),
		.q(ext_rst_tck_n)
	);
	dps_sync #(.W(1), .RST_VAL(1'h1)) u_xrst_clk (
		.clk(clk),
		.rst(rst),
		.d(ext_rst_n),
		.q(ext_rst_clk_n)
	);
	dps_sync #(.W(DBG_PINS), .RST_VAL(PIN_CFG_RST)) u_dbg_en (
		.clk(tck),
		.rst(rst_tck),
		.d(cfg_r.afsel),
		.q(dbg_en_tck)
	);
	dps_sync #(.W(1), .RST_VAL(1'h0)) u_erase (
		.clk(clk),
		.rst(rst),
		.d(erase_tgl_r),
		.q(erase_lvl)
	);

	// ********************************************
	// Link side: pattern and preamble detection
	// ********************************************
	logic [15:0] shr_r;
	logic [15:0] tlr_r;
	logic [5:0] ones_r;
	logic [3:0] sw_cnt_r;
	dps_mode_t mode_r;
	dps_tap_t tap_r;
	dps_tap_t tap_step;
	logic [3:0] ir_r;
	logic line_reset_r;

	// Gated pins stay silent to the detector
	wire link_en = dbg_en_tck[PIN_TCK] & dbg_en_tck[PIN_TMS];
	wire [15:0] shr_nxt = {tms_in, shr_r[15:1]};
	wire [15:0] tlr_nxt = {tlr_r[14:0], tap_r == TAP_TLR};
	// Preamble walk from reset encodes the same bits as the serial-wire pattern
	wire match_swd = link_en && shr_nxt == PAT_TO_SWD && tlr_nxt[15];
	wire match_jtag = link_en && shr_nxt == PAT_TO_JTAG && tlr_nxt[15];
	wire match_any = match_swd | match_jtag;
	wire [5:0] ones_nxt = !tms_in ? 6'h00 : (ones_r == ONES_MIN) ? ones_r : ones_r + 6'h01;
	wire line_reset_nxt = link_en && ones_nxt == ONES_MIN;
	wire sw_hit = match_any && sw_cnt_r != RECOVER_SWITCHES;
	wire [3:0] sw_cnt_nxt = !ext_rst_tck_n ? (sw_hit ? sw_cnt_r + 4'h1 : sw_cnt_r) : 4'h0;
	wire erase_fire = sw_hit && !ext_rst_tck_n && sw_cnt_nxt == RECOVER_SWITCHES;
	wire dps_tap_t tap_nxt = (mode_r == DPS_SWD || line_reset_nxt) ? TAP_TLR : tap_step;

	always_comb begin
		case (tap_r)
			TAP_TLR: tap_step = tms_in ? TAP_TLR : TAP_RTI;
			TAP_RTI: tap_step = tms_in ? TAP_SDR : TAP_RTI;
			TAP_SDR: tap_step = tms_in ? TAP_SIR : TAP_CDR;
			TAP_CDR: tap_step = tms_in ? TAP_E1DR : TAP_SHDR;
			TAP_SHDR: tap_step = tms_in ? TAP_E1DR : TAP_SHDR;
			TAP_E1DR: tap_step = tms_in ? TAP_UDR : TAP_PDR;
			TAP_PDR: tap_step = tms_in ? TAP_E2DR : TAP_PDR;
			TAP_E2DR: tap_step = tms_in ? TAP_UDR : TAP_SHDR;
			TAP_UDR: tap_step = tms_in ? TAP_SDR : TAP_RTI;
			TAP_SIR: tap_step = tms_in ? TAP_TLR : TAP_CIR;
			TAP_CIR: tap_step = tms_in ? TAP_E1IR : TAP_SHIR;
			TAP_SHIR: tap_step = tms_in ? TAP_E1IR : TAP_SHIR;
			TAP_E1IR: tap_step = tms_in ? TAP_UIR : TAP_PIR;
			TAP_PIR: tap_step = tms_in ? TAP_E2IR : TAP_PIR;
			TAP_E2IR: tap_step = tms_in ? TAP_UIR : TAP_SHIR;
			TAP_UIR: tap_step = tms_in ? TAP_SDR : TAP_RTI;
			default: tap_step = TAP_TLR;
		endcase
	end

	always_ff @(posedge tck) begin
		if (rst_tck) begin
			shr_r <= 16'h0000;
			tlr_r <= 16'h0000;
			ones_r <= 6'h00;
			line_reset_r <= 1'b0;
		end else if (link_en) begin
			shr_r <= shr_nxt;
			tlr_r <= tlr_nxt;
			ones_r <= ones_nxt;
			line_reset_r <= line_reset_nxt;
		end
	end

	always_ff @(posedge tck) begin
		if (rst_tck) begin
			tap_r <= TAP_TLR;
			ir_r <= IR_DEFAULT;
		end else if (link_en) begin
			tap_r <= tap_nxt;
			ir_r <= (tap_nxt == TAP_TLR) ? IR_DEFAULT : ir_r;
		end
	end

	// mode changes only on a match
	always_ff @(posedge tck) begin
		if (rst_tck) begin
			mode_r <= DPS_JTAG;
		end else if (match_swd) begin
			mode_r <= DPS_SWD;
		end else if (match_jtag) begin
			mode_r <= DPS_JTAG;
		end
	end

	always_ff @(posedge tck) begin
		if (rst_tck) begin
			sw_cnt_r <= 4'h0;
			erase_tgl_r <= 1'b0;
		end else begin
			sw_cnt_r <= sw_cnt_nxt;
			erase_tgl_r <= erase_tgl_r ^ erase_fire;
		end
	end

	// ********************************************
	// System side: pin configuration
	// ********************************************
	logic unlocked_r;
	logic [4:0] commit_r;
	wire [4:0] af_allow = {5{unlocked_r}} & commit_r;
	wire [4:0] af_wdata = (cfg_data & af_allow) | (cfg_r.afsel & ~af_allow);
	wire af_wr = cfg_wr && cfg_sel == SEL_AFSEL;

	always_ff @(posedge clk) begin
		if (rst || !ext_rst_clk_n) begin
			cfg_r <= '{den: PIN_CFG_RST, pur: PIN_CFG_RST, afsel: PIN_CFG_RST};
		end else begin
			if (cfg_wr && cfg_sel == SEL_DEN) begin
				cfg_r.den <= cfg_data;
			end
			if (cfg_wr && cfg_sel == SEL_PUR) begin
				cfg_r.pur <= cfg_data;
			end
			if (dbg_restore) begin
				cfg_r.afsel <= PIN_CFG_RST;
			end else if (af_wr) begin
				cfg_r.afsel <= af_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !ext_rst_clk_n) begin
			unlocked_r <= 1'b0;
			commit_r <= COMMIT_RST;
		end else begin
			if (lock_wr) begin
				unlocked_r <= lock_key == UNLOCK_KEY;
			end
			if (commit_wr && unlocked_r) begin
				commit_r <= commit_data;
			end
		end
	end

	// ********************************************
	// System side: recovery sequencing
	// ********************************************
	logic erase_d_r;
	dps_rec_t rec_r;
	logic flash_erase_req_r;
	logic nv_restore_req_r;
	wire erase_evt = erase_lvl ^ erase_d_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			erase_d_r <= 1'b0;
			rec_r <= REC_IDLE;
			flash_erase_req_r <= 1'b0;
			nv_restore_req_r <= 1'b0;
		end else begin
			erase_d_r <= erase_lvl;
			case (rec_r)
				REC_IDLE: begin
					if (erase_evt) begin
						rec_r <= REC_ERASE;
						flash_erase_req_r <= 1'b1;
					end
				end
				REC_ERASE: begin
					if (flash_erase_done) begin
						rec_r <= REC_RESTORE;
						flash_erase_req_r <= 1'b0;
						nv_restore_req_r <= 1'b1;
					end
				end
				REC_RESTORE: begin
					if (nv_restore_done) begin
						rec_r <= REC_IDLE;
						nv_restore_req_r <= 1'b0;
					end
				end
				default: begin
					rec_r <= REC_IDLE;
					flash_erase_req_r <= 1'b0;
					nv_restore_req_r <= 1'b0;
				end
			endcase
		end
	end

	assign pin_cfg = cfg_r;
	assign pin_unlocked = unlocked_r;
	assign pin_commit = commit_r;
	assign flash_erase_req = flash_erase_req_r;
	assign nv_restore_req = nv_restore_req_r;
	assign port_mode = mode_r;
	assign line_reset = line_reset_r;
	assign tap_state = tap_r;
	assign ir_value = ir_r;

	// ********************************************
	// Checks
	// ********************************************
	sequence s_erase_done;
		flash_erase_req_r && flash_erase_done;
	endsequence
	sequence s_restore_start;
		nv_restore_req_r && !flash_erase_req_r;
	endsequence

	a_reset_pin_defaults: assert property (@(posedge clk) disable iff (rst)
		!ext_rst_clk_n |=> cfg_r.afsel == 5'h1F && cfg_r.den == 5'h1F && cfg_r.pur == 5'h1F)
		else $error("pins not at debug defaults after reset");
	a_afsel_commit_write: assert property (@(posedge clk) disable iff (rst)
		af_wr && !dbg_restore && ext_rst_clk_n && unlocked_r && commit_r == 5'h1F
		|=> cfg_r.afsel == $past(cfg_data))
		else $error("committed alternate select write lost");
	a_locked_write_drop: assert property (@(posedge clk) disable iff (rst)
		af_wr && !unlocked_r && !dbg_restore && ext_rst_clk_n |=> $stable(cfg_r.afsel))
		else $error("locked alternate select write took effect");
	a_erase_then_restore: assert property (@(posedge clk) disable iff (rst)
		s_erase_done |=> s_restore_start)
		else $error("restore did not follow erase");
	a_restore_after_erase: assert property (@(posedge clk) disable iff (rst)
		$rose(nv_restore_req_r) |-> $past(flash_erase_req_r) && $past(flash_erase_done))
		else $error("restore started before erase done");
	a_recovery_count: assert property (@(posedge tck) disable iff (rst_tck)
		!ext_rst_tck_n && match_any && sw_cnt_r == 4'h9 |=> erase_tgl_r != $past(erase_tgl_r))
		else $error("tenth switch did not request erase");
	a_swd_switch: assert property (@(posedge tck) disable iff (rst_tck)
		match_swd |=> mode_r == DPS_SWD)
		else $error("serial-wire pattern not honoured");
	a_jtag_switch: assert property (@(posedge tck) disable iff (rst_tck)
		match_jtag |=> mode_r == DPS_JTAG)
		else $error("JTAG pattern not honoured");
	a_mode_hold: assert property (@(posedge tck) disable iff (rst_tck)
		!match_any |=> $stable(mode_r))
		else $error("mode changed without a pattern");
	a_ones_line_reset: assert property (@(posedge tck) disable iff (rst_tck)
		link_en && tms_in && ones_r == 6'h31 |=> line_reset_r && tap_r == TAP_TLR)
		else $error("fifty ones did not reset the link");
	a_tap_five_ones: assert property (@(posedge tck) disable iff (rst_tck)
		(link_en && tms_in) [*5] |=> tap_r == TAP_TLR && ir_r == 4'hE)
		else $error("five ones did not reach test-logic-reset");
	a_gpio_silent: assert property (@(posedge tck) disable iff (rst_tck)
		!link_en |=> $stable(shr_r) && $stable(tap_r))
		else $error("released pins still drive debug logic");
endmodule : dps_mode_switch

//--- rtl/dps_pkg.sv
// Notes on behaviour
// - After power-on or external reset, all five debug pins enable digital, pull-up, alternate.
// - Clearing alternate-select bits turns those debug pins into general-purpose I/O.
// - Alternate-select writes are dropped unless unlocked and the matching commit bits are set.
// - Ten switch sequences in total while external reset is held trigger flash mass erase.
// - Recovery erases flash first, then restores nonvolatile configuration to defaults.
// - A three-round TAP walk starting from Test-Logic-Reset enables serial-wire, disables JTAG.
// - Pattern 16'hE79E, sent LSB first, switches the port to serial-wire mode.
// - Pattern 16'hE73C, sent LSB first, switches the port back to JTAG mode.
// - Fifty consecutive high cycles reset both the JTAG and serial-wire logic.
// - Pins turned into general-purpose I/O carry no debug traffic until re-selected.
// - An external or software trigger restores debug pin functions to avoid lockout.
// - Five consecutive high mode-select cycles reach Test-Logic-Reset and reload identify instruction.
// - Mode-select is sampled on the rising edge of the test clock.
package dps_pkg;
	localparam int DBG_PINS = 5;
	// Pin slots: port C bits 0..3, then port B bit 7
	localparam int PIN_TCK = 0;
	localparam int PIN_TMS = 1;
	localparam logic [4:0] PIN_CFG_RST = 5'h1F;
	localparam logic [4:0] COMMIT_RST = 5'h00;
	localparam logic [15:0] PAT_TO_SWD = 16'hE79E;
	localparam logic [15:0] PAT_TO_JTAG = 16'hE73C;
	localparam logic [5:0] ONES_MIN = 6'h32;
	localparam logic [3:0] RECOVER_SWITCHES = 4'hA;
	localparam logic [3:0] IR_DEFAULT = 4'hE;
	localparam logic [1:0] SEL_DEN = 2'h0;
	localparam logic [1:0] SEL_PUR = 2'h1;
	localparam logic [1:0] SEL_AFSEL = 2'h2;
	// Arbitrary unlock key value
	localparam logic [31:0] UNLOCK_KEY = 32'h5A5A0F0F;

	typedef struct packed {
		logic [4:0] den;
		logic [4:0] pur;
		logic [4:0] afsel;
	} dps_pin_cfg_t;

	typedef enum logic {DPS_JTAG, DPS_SWD} dps_mode_t;

	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI, TAP_SDR, TAP_CDR, TAP_SHDR, TAP_E1DR, TAP_PDR, TAP_E2DR,
		TAP_UDR, TAP_SIR, TAP_CIR, TAP_SHIR, TAP_E1IR, TAP_PIR, TAP_E2IR, TAP_UIR
	} dps_tap_t;

	typedef enum logic [1:0] {REC_IDLE, REC_ERASE, REC_RESTORE} dps_rec_t;
endpackage : dps_pkg

//--- rtl/dps_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; output follows once stages two and three agree
module dps_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk, // destination clock
	input wire logic rst, // synchronous reset, high
	input wire logic [W-1:0] d, // foreign level
	output logic [W-1:0] q // filtered level
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	wire [W-1:0] agree = ~(s2_r ^ s3_r);
	wire [W-1:0] q_nxt = (s2_r & agree) | (q_r & ~agree);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule : dps_sync

//--- verif/dps_probe_model.sv
`timescale 1ns/100ps
module dps_probe_model (
	output logic tck, // probe clock, still between frames
	output logic tms // mode-select line, pulled up when idle
);
	// ********************
	// Bit-level drive
	// ********************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
	end

	task automatic bit_out(input logic b);
		tms = b;
		#40 tck = 1'b1;
		#40 tck = 1'b0;
	endtask : bit_out

	// Odd start offset keeps tck unrelated in phase to clk
	// framing ones
	task automatic ones(input int n);
		#3.3;
		repeat (n) bit_out(1'b1);
	endtask : ones

	task automatic pat(input logic [15:0] p);
		for (int i = 0; i < 16; i++) bit_out(p[i]);
		tms = 1'b1;
	endtask : pat
endmodule : dps_probe_model

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import dps_pkg::*;
	logic clk, rst, ext_rst_n, cfg_wr, lock_wr, commit_wr, dbg_restore;
	logic [1:0] cfg_sel;
	logic [4:0] cfg_data, commit_data, pin_commit;
	logic [31:0] lock_key;
	logic flash_erase_done, nv_restore_done, tck, tms_in;
	logic pin_unlocked, flash_erase_req, nv_restore_req, line_reset;
	logic [3:0] ir_value;
	dps_pin_cfg_t pin_cfg;
	dps_mode_t port_mode;
	dps_tap_t tap_state;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	dps_probe_model i_dps_probe_model (.tck(tck), .tms(tms_in));

	dps_mode_switch i_dps_mode_switch (.clk(clk), .rst(rst), .tck(tck), .tms_in(tms_in),
		.ext_rst_n(ext_rst_n), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
		.lock_wr(lock_wr), .lock_key(lock_key), .commit_wr(commit_wr),
		.commit_data(commit_data), .dbg_restore(dbg_restore),
		.flash_erase_done(flash_erase_done), .nv_restore_done(nv_restore_done),
		.pin_cfg(pin_cfg), .pin_unlocked(pin_unlocked), .pin_commit(pin_commit),
		.flash_erase_req(flash_erase_req), .nv_restore_req(nv_restore_req),
		.port_mode(port_mode), .line_reset(line_reset), .tap_state(tap_state),
		.ir_value(ir_value));

	// ********************
	// Access and checking
	// ********************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	// Hangs in the link would otherwise stall the run forever
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	// k: 0 config field, 1 lock key, 2 commit bits
	task automatic put(input int k, input logic [1:0] s, input logic [31:0] d);
		@(posedge clk);
		cfg_sel <= s;
		cfg_data <= d[4:0];
		commit_data <= d[4:0];
		lock_key <= d;
		cfg_wr <= (k == 0);
		lock_wr <= (k == 1);
		commit_wr <= (k == 2);
		@(posedge clk);
		cfg_wr <= 1'b0;
		lock_wr <= 1'b0;
		commit_wr <= 1'b0;
		// Return where the written field has settled
		@(negedge clk);
	endtask : put

	task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
		@(negedge clk);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// ********************
	// Main sequence
	// ********************
	initial begin
		rst = 1'b1;
		ext_rst_n = 1'b1;
		{cfg_wr, lock_wr, commit_wr, dbg_restore} = 4'h0;
		{flash_erase_done, nv_restore_done} = 2'h0;
		cfg_sel = 2'h0;
		cfg_data = 5'h00;
		commit_data = 5'h00;
		lock_key = 32'h00000000;
		repeat (10) @(posedge clk);
		i_dps_probe_model.ones(6);
		@(posedge clk);
		rst <= 1'b0;
		chk("pin_cfg", 15'h7FFF, pin_cfg);
		chk("mode", {14'h0000, DPS_JTAG}, {14'h0000, port_mode});
		chk("tap", 15'h0000, {11'h000, tap_state});
		chk("ir", 15'h000E, {11'h000, ir_value});
		put(0, SEL_AFSEL, 32'h00000000);
		chk("pin_cfg", 15'h7FFF, pin_cfg);
		put(1, SEL_DEN, UNLOCK_KEY);
		put(2, SEL_DEN, 32'h0000001C);
		put(0, SEL_AFSEL, 32'h00000000);
		chk("unlocked", 15'h0001, {14'h0000, pin_unlocked});
		chk("commit", 15'h001C, {10'h000, pin_commit});
		chk("pin_cfg", 15'h7FE3, pin_cfg);
		put(0, SEL_DEN, 32'h0000000A);
		chk("pin_cfg", 15'h2BE3, pin_cfg);
		// Link logic wakes four edges after reset crosses
		i_dps_probe_model.ones(4);
		i_dps_probe_model.ones(50);
		chk("line_reset", 15'h0001, {14'h0000, line_reset});
		i_dps_probe_model.pat(16'hE79E);
		i_dps_probe_model.ones(50);
		chk("mode", {14'h0000, DPS_SWD}, {14'h0000, port_mode});
		i_dps_probe_model.pat(16'hE73C);
		i_dps_probe_model.ones(5);
		chk("mode", {14'h0000, DPS_JTAG}, {14'h0000, port_mode});
		chk("tap", 15'h0000, {11'h000, tap_state});
		i_dps_probe_model.bit_out(1'b0);
		chk("tap", 15'h0001, {11'h000, tap_state});
		i_dps_probe_model.ones(5);
		chk("tap", 15'h0000, {11'h000, tap_state});
		chk("ir", 15'h000E, {11'h000, ir_value});
		// Preamble walk with only the short lead of ones
		i_dps_probe_model.pat(16'hE79E);
		i_dps_probe_model.ones(5);
		chk("mode", {14'h0000, DPS_SWD}, {14'h0000, port_mode});
		i_dps_probe_model.ones(50);
		i_dps_probe_model.pat(16'hE73C);
		i_dps_probe_model.ones(5);
		put(2, SEL_DEN, 32'h00000003);
		put(0, SEL_AFSEL, 32'h00000000);
		chk("pin_cfg", 15'h2BE0, pin_cfg);
		i_dps_probe_model.ones(50);
		i_dps_probe_model.pat(16'hE79E);
		i_dps_probe_model.ones(50);
		chk("mode", {14'h0000, DPS_JTAG}, {14'h0000, port_mode});
		@(posedge clk);
		dbg_restore <= 1'b1;
		@(posedge clk);
		dbg_restore <= 1'b0;
		@(negedge clk);
		chk("pin_cfg", 15'h2BFF, pin_cfg);
		@(posedge clk);
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("pin_cfg", 15'h7FFF, pin_cfg);
		chk("unlocked", 15'h0000, {14'h0000, pin_unlocked});
		for (int n = 0; n < 10; n++) begin
			i_dps_probe_model.ones(50);
			i_dps_probe_model.pat(n[0] ? 16'hE73C : 16'hE79E);
			if (n == 8) begin
				i_dps_probe_model.ones(5);
				repeat (20) @(posedge clk);
				chk("erase_req", 15'h0000, {14'h0000, flash_erase_req});
			end
		end
		i_dps_probe_model.ones(5);
		for (int i = 0; i < 40; i++) if (flash_erase_req !== 1'b1) @(negedge clk);
		chk("erase_req", 15'h0001, {14'h0000, flash_erase_req});
		chk("nv_req", 15'h0000, {14'h0000, nv_restore_req});
		@(posedge clk);
		flash_erase_done <= 1'b1;
		@(posedge clk);
		flash_erase_done <= 1'b0;
		for (int i = 0; i < 10; i++) if (nv_restore_req !== 1'b1) @(negedge clk);
		chk("nv_req", 15'h0001, {14'h0000, nv_restore_req});
		chk("erase_req", 15'h0000, {14'h0000, flash_erase_req});
		@(posedge clk);
		nv_restore_done <= 1'b1;
		@(posedge clk);
		nv_restore_done <= 1'b0;
		repeat (3) @(posedge clk);
		chk("nv_req", 15'h0000, {14'h0000, nv_restore_req});
		ext_rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		// Fully committed write, pull-up field, then relock
		put(1, SEL_DEN, UNLOCK_KEY);
		put(2, SEL_DEN, 32'h0000001F);
		put(0, SEL_AFSEL, 32'h00000015);
		chk("pin_cfg", 15'h7FF5, pin_cfg);
		put(0, SEL_PUR, 32'h0000000C);
		chk("pin_cfg", 15'h7D95, pin_cfg);
		put(1, SEL_DEN, 32'h00000000);
		put(2, SEL_DEN, 32'h00000000);
		chk("unlocked", 15'h0000, {14'h0000, pin_unlocked});
		chk("commit", 15'h001F, {10'h000, pin_commit});
		stop_test();
	end
endmodule : tb_top
